// ### rtl/lcd_output_mode_config_regs.vh
// Register indices, field positions, reset values and codes for LCD mode
`ifndef LCD_OUTPUT_MODE_CONFIG_REGS_VH
`define LCD_OUTPUT_MODE_CONFIG_REGS_VH

// Register indices; byte address is four times the index
`define VSYNC_START_POSITION_IDX    8'h26
`define PIXEL_CLOCK_EDGE_SELECT_IDX 8'h28
`define DISPLAY_MODE_CONTROL_IDX    8'h2A
`define WINDOW_ONE_ADDR_LOW_IDX     8'h2C
`define WINDOW_ONE_ADDR_MID_IDX     8'h2E
`define WINDOW_ONE_ADDR_HIGH_IDX    8'h30
`define CONFIG_COMMIT_IDX           8'h50

// Field positions
`define PCLK_EDGE_BIT      7
`define COMMIT_BIT         7
`define IF_ENABLE_BIT      0
`define OUT_SEL_LSB        1
`define OUT_SEL_MSB        3
`define BUF_SEL_LSB        4
`define BUF_SEL_MSB        7
`define ADDR_LOW_LSB       3

// Reset values
`define VSYNC_START_RESET  8'h00
`define PCLK_EDGE_RESET    1'b0
`define PCLK_RSVD_RESET    3'h0
`define MODE_RESET         8'h00
`define MODE_FIELDS_RESET  7'h00
`define ADDR_LOW_RESET     5'h00
`define ADDR_MID_RESET     8'h00
`define ADDR_HIGH_RESET    8'h00

// Output source codes
`define SRC_SINGLE         3'h0
`define SRC_DOUBLE         3'h1
`define SRC_WINDOW_ONE     3'h2
`define SRC_WINDOW_TWO     3'h3
`define SRC_BOTH_WINDOWS   3'h4
`define SRC_BLANK_LOW      3'h5
`define SRC_BLANK_HIGH     3'h6
`define SRC_COLOUR_BAR     3'h7

// Double buffer fixed pair, first buffer index
`define DOUBLE_PAIR_BASE   4'h0

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### rtl/pixel_clock_launch.v
// Pixel clock divider with data launch on the selected edge
`timescale 1ns/1ps
`default_nettype none

module pixel_clock_launch
(
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       run,
  input  wire       falling_edge_sel,
  output reg        pclk_reg,
  output wire       launch
);

  // Pixel clock at half of mclk, parked low while stopped
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pclk_reg <= 1'b0;
    else if (run)
      pclk_reg <= ~pclk_reg;
    else
      pclk_reg <= 1'b0;
  end

  // Data flop updates on the same mclk edge that moves pclk, so new
  // data appears on pclk rising (sel 0) or falling (sel 1)
  assign launch = run & (pclk_reg == falling_edge_sel);

endmodule

`default_nettype wire

// ### rtl/vsync_placer.v
// Places vertical sync start a set number of lines into non-display
`timescale 1ns/1ps
`default_nettype none

module vsync_placer
(
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       run,
  input  wire       non_display_start,
  input  wire       line_strobe,
  input  wire [7:0] start_lines,
  output reg        vsync_start_reg
);

  reg  [8:0] line_cnt_reg;  // Lines since non-display start
  reg        armed_reg;     // Waiting for the start line

  // Count lines; one pulse when the count meets the start position
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_cnt_reg    <= 9'h000;
      armed_reg       <= 1'b0;
      vsync_start_reg <= 1'b0;
    end
    else if (!run)
    begin
      line_cnt_reg    <= 9'h000;
      armed_reg       <= 1'b0;
      vsync_start_reg <= 1'b0;
    end
    else if (non_display_start)
    begin
      // Zero offset starts sync on the first non-display line
      line_cnt_reg    <= 9'h000;
      armed_reg       <= (start_lines != 8'h00);
      vsync_start_reg <= (start_lines == 8'h00);
    end
    else if (armed_reg && line_strobe)
    begin
      line_cnt_reg    <= line_cnt_reg + 9'h001;
      // Compare against next count so the pulse lands on that line
      if ((line_cnt_reg + 9'h001) == {1'b0, start_lines})
      begin
        vsync_start_reg <= 1'b1;
        armed_reg       <= 1'b0;
      end
      else
        vsync_start_reg <= 1'b0;
    end
    else
      vsync_start_reg <= 1'b0;
  end

endmodule

`default_nettype wire

// ### rtl/lcd_output_mode_config.v
// LCD output mode configuration with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "lcd_output_mode_config_regs.vh"

module lcd_output_mode_config
(
  input  wire        mclk,
  input  wire        rst_b,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timing and pixel path, same clock
  input  wire        non_display_start,
  input  wire        line_strobe,
  input  wire [23:0] pixel_in,
  // Panel and fetch side
  output reg         lcd_enable,
  output reg  [2:0]  output_source,
  output reg  [3:0]  frame_buffer_index,
  output reg         double_buffer_active,
  output reg  [23:0] window_one_start_addr,
  output wire        pclk_out,
  output wire        vsync_start,
  output reg  [23:0] panel_data
);

  // Software copies
  reg  [7:0]  vsync_start_reg;    // Vsync start offset, immediate
  reg         pclk_edge_reg;      // Launch edge select
  reg         if_enable_reg;      // Interface enable, immediate
  reg  [6:0]  mode_shadow_reg;    // Mode bits 7..1 awaiting commit
  reg  [4:0]  addr_low_reg;       // Window address bits 7..3
  reg  [7:0]  addr_mid_reg;       // Window address bits 15..8
  reg  [7:0]  addr_high_reg;      // Window address bits 23..16
  // Working copies used by the display
  reg  [6:0]  mode_work_reg;      // Committed mode bits 7..1
  reg  [20:0] addr_work_reg;      // Committed address bits 23..3
  // Bus state and colour bar position
  reg         aw_have_reg;        // Write address captured
  reg         w_have_reg;         // Write data captured
  reg  [7:0]  waddr_idx_reg;      // Captured write index
  reg  [7:0]  wdata_reg;          // Captured low byte
  reg         wlane_reg;          // Low byte lane enabled
  reg  [3:0]  bar_cnt_reg;        // Colour bar column prescale
  reg  [2:0]  bar_idx_reg;        // Colour bar number

  wire        launch;
  wire        do_write;
  wire [2:0]  work_src;
  wire [7:0]  rd_idx;
  wire        ar_take;

  // Index from a byte address; decode shared by both paths
  function [7:0] addr_to_idx;
    input [11:0] addr;
    begin
      addr_to_idx = addr[9:2];
    end
  endfunction

  // Whether an index names a register of this block
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `VSYNC_START_POSITION_IDX,
        `PIXEL_CLOCK_EDGE_SELECT_IDX,
        `DISPLAY_MODE_CONTROL_IDX,
        `WINDOW_ONE_ADDR_LOW_IDX,
        `WINDOW_ONE_ADDR_MID_IDX,
        `WINDOW_ONE_ADDR_HIGH_IDX,
        `CONFIG_COMMIT_IDX:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  assign work_src   = mode_work_reg[2:0];
  assign do_write   = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign rd_idx     = addr_to_idx(s_axi_araddr);
  assign ar_take    = s_axi_arvalid & s_axi_arready;

  // Write address channel: take once, hold until response is issued
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_have_reg   <= 1'b0;
      waddr_idx_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_reg   <= 1'b1;
      waddr_idx_reg <= addr_to_idx(s_axi_awaddr);
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
      aw_have_reg   <= 1'b0;
    else
      // Ready only while free and no response pending
      s_axi_awready <= ~aw_have_reg & ~s_axi_bvalid;
  end

  // Write data channel: either order against the address
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      w_have_reg   <= 1'b0;
      wdata_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_reg   <= 1'b1;
      wdata_reg    <= s_axi_wdata[7:0];
      wlane_reg    <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
      w_have_reg   <= 1'b0;
    else
      s_axi_wready <= ~w_have_reg & ~s_axi_bvalid;
  end

  // Write response, one cycle after both halves are held
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      // Unmapped address answers with slave error
      s_axi_bresp  <= is_mapped(waddr_idx_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register writes; only byte lane 0 carries data
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vsync_start_reg <= `VSYNC_START_RESET;
      pclk_edge_reg   <= `PCLK_EDGE_RESET;
      if_enable_reg   <= 1'b0;
      mode_shadow_reg <= `MODE_FIELDS_RESET;
      addr_low_reg    <= `ADDR_LOW_RESET;
      addr_mid_reg    <= `ADDR_MID_RESET;
      addr_high_reg   <= `ADDR_HIGH_RESET;
    end
    else if (do_write && wlane_reg)
    begin
      case (waddr_idx_reg)
        `VSYNC_START_POSITION_IDX:
          vsync_start_reg <= wdata_reg;
        `PIXEL_CLOCK_EDGE_SELECT_IDX:
          pclk_edge_reg   <= wdata_reg[`PCLK_EDGE_BIT];
        `DISPLAY_MODE_CONTROL_IDX:
        begin
          // Enable bypasses the shadow; the rest waits for commit
          if_enable_reg   <= wdata_reg[`IF_ENABLE_BIT];
          mode_shadow_reg <= wdata_reg[7:1];
        end
        `WINDOW_ONE_ADDR_LOW_IDX:
          addr_low_reg    <= wdata_reg[7:`ADDR_LOW_LSB];
        `WINDOW_ONE_ADDR_MID_IDX:
          addr_mid_reg    <= wdata_reg;
        `WINDOW_ONE_ADDR_HIGH_IDX:
          addr_high_reg   <= wdata_reg;
        default: vsync_start_reg <= vsync_start_reg;
      endcase
    end
  end

  // Commit copies shadows to working copies, running or not
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_work_reg <= `MODE_FIELDS_RESET;
      addr_work_reg <= {`ADDR_HIGH_RESET, `ADDR_MID_RESET, `ADDR_LOW_RESET};
    end
    else if (do_write && wlane_reg &&
             waddr_idx_reg == `CONFIG_COMMIT_IDX &&
             wdata_reg[`COMMIT_BIT])
    begin
      mode_work_reg <= mode_shadow_reg;
      addr_work_reg <= {addr_high_reg, addr_mid_reg,
                        addr_low_reg};
    end
  end

  // Read channel; commit register reads zero, it self-clears
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (rd_idx)
        `VSYNC_START_POSITION_IDX:
          s_axi_rdata <= {24'h000000, vsync_start_reg};
        `PIXEL_CLOCK_EDGE_SELECT_IDX:
          s_axi_rdata <= {24'h000000, pclk_edge_reg, 4'h0,
                          `PCLK_RSVD_RESET};
        `DISPLAY_MODE_CONTROL_IDX:
          s_axi_rdata <= {24'h000000, mode_shadow_reg, if_enable_reg};
        `WINDOW_ONE_ADDR_LOW_IDX:
          s_axi_rdata <= {24'h000000, addr_low_reg, 3'h0};
        `WINDOW_ONE_ADDR_MID_IDX:
          s_axi_rdata <= {24'h000000, addr_mid_reg};
        `WINDOW_ONE_ADDR_HIGH_IDX:
          s_axi_rdata <= {24'h000000, addr_high_reg};
        default:
          s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      // Data held until the master takes it
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Display-facing configuration outputs, registered
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lcd_enable            <= 1'b0;
      output_source         <= `SRC_SINGLE;
      frame_buffer_index    <= 4'h0;
      double_buffer_active  <= 1'b0;
      window_one_start_addr <= 24'h000000;
    end
    else
    begin
      lcd_enable            <= if_enable_reg;
      output_source         <= work_src;
      double_buffer_active  <= (work_src == `SRC_DOUBLE);
      // Code n is buffer n+1, so the index passes through as is
      frame_buffer_index    <= (work_src == `SRC_DOUBLE)
                               ? `DOUBLE_PAIR_BASE
                               : mode_work_reg[6:3];
      window_one_start_addr <= {addr_work_reg, 3'h0};
    end
  end

  pixel_clock_launch u_pclk
  (
    .mclk             (mclk),
    .rst_b            (rst_b),
    .run              (lcd_enable),
    .falling_edge_sel (pclk_edge_reg),
    .pclk_reg         (pclk_out),
    .launch           (launch)
  );

  vsync_placer u_vsync
  (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .run               (lcd_enable),
    .non_display_start (non_display_start),
    .line_strobe       (line_strobe),
    .start_lines       (vsync_start_reg),
    .vsync_start_reg   (vsync_start)
  );

  // Colour bar position: eight bars, each 16 pixel launches wide
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bar_cnt_reg <= 4'h0;
      bar_idx_reg <= 3'h0;
    end
    else if (line_strobe || !lcd_enable)
    begin
      bar_cnt_reg <= 4'h0;
      bar_idx_reg <= 3'h0;
    end
    else if (launch)
    begin
      bar_cnt_reg <= bar_cnt_reg + 4'h1;
      if (bar_cnt_reg == 4'hF)
        bar_idx_reg <= bar_idx_reg + 3'h1;
    end
  end

  // Panel data launched on the selected pixel clock edge
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      panel_data <= 24'h000000;
    else if (!lcd_enable)
      panel_data <= 24'h000000;
    else if (launch)
    begin
      case (output_source)
        `SRC_BLANK_LOW:
          panel_data <= 24'h000000;
        `SRC_BLANK_HIGH:
          panel_data <= 24'hFFFFFF;
        `SRC_COLOUR_BAR:
          panel_data <= {{8{bar_idx_reg[2]}}, {8{bar_idx_reg[1]}},
                         {8{bar_idx_reg[0]}}};
        // Buffer and window sources come from the fetch path
        default:
          panel_data <= pixel_in;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### tb/lcd_output_mode_config_checker.sv
// Assertion checker for the LCD output mode configuration block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_output_mode_config_regs.vh"

module lcd_output_mode_config_checker
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        lcd_enable,
  input wire logic [2:0]  output_source,
  input wire logic [3:0]  frame_buffer_index,
  input wire logic        double_buffer_active,
  input wire logic [23:0] window_one_start_addr,
  input wire logic        pclk_out,
  input wire logic        vsync_start
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_dbl_flag;
    double_buffer_active == (output_source == `SRC_DOUBLE);
  endproperty
  a_dbl_flag: assert property (p_dbl_flag)
    else $error("double flag disagrees with source");
  property p_dbl_index;
    double_buffer_active |-> frame_buffer_index == `DOUBLE_PAIR_BASE;
  endproperty
  a_dbl_index: assert property (p_dbl_index)
    else $error("buffer index not pair base");
  property p_addr_align;
    window_one_start_addr[2:0] == 3'h0;
  endproperty
  a_addr_align: assert property (p_addr_align)
    else $error("window address not aligned");
  // Working copies may move only around a write response
  property p_mode_commit;
    $changed(output_source) || $changed(frame_buffer_index)
      |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_mode_commit: assert property (p_mode_commit)
    else $error("mode changed without a write");
  property p_win_commit;
    $changed(window_one_start_addr) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_win_commit: assert property (p_win_commit)
    else $error("window address changed without a write");
  property p_pclk_idle;
    !lcd_enable ##1 !lcd_enable |-> !pclk_out;
  endproperty
  a_pclk_idle: assert property (p_pclk_idle)
    else $error("pixel clock runs while disabled");
  property p_pclk_run;
    lcd_enable [*4] |-> pclk_out != $past(pclk_out);
  endproperty
  a_pclk_run: assert property (p_pclk_run)
    else $error("pixel clock not toggling");
  property p_vs_pulse;
    vsync_start |=> !vsync_start;
  endproperty
  a_vs_pulse: assert property (p_vs_pulse)
    else $error("vsync start longer than one cycle");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read response late");

  // Main scenarios reached
  c_double: cover property (double_buffer_active);
  c_vsync: cover property (vsync_start);
  c_window: cover property ($changed(window_one_start_addr));
endmodule

bind lcd_output_mode_config lcd_output_mode_config_checker i_chk (
  .mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .lcd_enable(lcd_enable),
  .output_source(output_source), .frame_buffer_index(frame_buffer_index),
  .double_buffer_active(double_buffer_active),
  .window_one_start_addr(window_one_start_addr),
  .pclk_out(pclk_out), .vsync_start(vsync_start));
`default_nettype wire

// ### tb/lcd_panel_model.sv
// Panel model that latches data on the chosen pixel clock edge
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_model
(
  input  wire logic        mclk,
  input  wire logic        pclk_out,
  input  wire logic [23:0] panel_data,
  input  wire logic        edge_fall,
  output wire logic [15:0] hit_cnt,
  output wire logic [15:0] miss_cnt
);
  logic        pclk_q = 1'b0;        // Pixel clock one cycle ago
  logic [23:0] data_q = 24'h000000;  // Data one cycle ago
  logic [15:0] hits_q = 16'h0000;    // Changes on the latch edge
  logic [15:0] misses_q = 16'h0000;  // Changes off the latch edge

  assign hit_cnt = hits_q;
  assign miss_cnt = misses_q;

  // Data may only move with the latch edge, else the panel sees a tear
  always @(posedge mclk)
  begin
    if (panel_data !== data_q)
    begin
      if (pclk_out !== pclk_q && pclk_out === !edge_fall)
        hits_q <= hits_q + 16'h0001;
      else
        misses_q <= misses_q + 16'h0001;
    end
    pclk_q <= pclk_out;
    data_q <= panel_data;
  end
endmodule
`default_nettype wire

// ### tb/test_lcd_output_mode_config.sv
// Self-checking bench for the LCD output mode configuration block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_output_mode_config_regs.vh"

module test_lcd_output_mode_config;
  localparam logic [11:0] A_VS = {2'b00, `VSYNC_START_POSITION_IDX, 2'b00};
  localparam logic [11:0] A_EDGE =
    {2'b00, `PIXEL_CLOCK_EDGE_SELECT_IDX, 2'b00};
  localparam logic [11:0] A_MODE = {2'b00, `DISPLAY_MODE_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_LO = {2'b00, `WINDOW_ONE_ADDR_LOW_IDX, 2'b00};
  localparam logic [11:0] A_MID = {2'b00, `WINDOW_ONE_ADDR_MID_IDX, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, `WINDOW_ONE_ADDR_HIGH_IDX, 2'b00};
  localparam logic [11:0] A_COMMIT = {2'b00, `CONFIG_COMMIT_IDX, 2'b00};
  localparam logic [11:0] A_NONE = 12'h3FC;   // Unmapped word

  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        non_display_start = 1'b0;
  logic        line_strobe = 1'b0;
  logic        edge_fall = 1'b0;
  logic [23:0] pixel_in = 24'h000000;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, lcd_enable, double_buffer_active;
  wire         pclk_out, vsync_start;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [2:0]  output_source;
  wire  [3:0]  frame_buffer_index;
  wire  [23:0] window_one_start_addr, panel_data;
  wire  [15:0] hit_cnt, miss_cnt;
  integer      n_errors = 0;
  integer      tests_run = 0;

  lcd_output_mode_config i_dut (.*);
  lcd_panel_model i_panel (.mclk(mclk), .pclk_out(pclk_out),
    .panel_data(panel_data), .edge_fall(edge_fall),
    .hit_cnt(hit_cnt), .miss_cnt(miss_cnt));

  // Clock and a moving pixel stream so every launch is visible
  always #5 mclk = ~mclk;
  always @(posedge mclk) pixel_in <= pixel_in + 24'h000001;

  task stop_test;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    n_errors = n_errors + 1;
    $display("BAD %0t bus wait ran out", $time);
    stop_test();
  endtask

  // Register write; both channels offered at once, response checked
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    integer k;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k = k + 1)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (k == 40) hang();
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Register read compared with expected data and response
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    integer k;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k = k + 1)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (k == 40) hang();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task t_reset_values;
    rd(A_VS, 32'h0, `RESP_OKAY);
    rd(A_EDGE, 32'h0, `RESP_OKAY);
    rd(A_MODE, 32'h0, `RESP_OKAY);
    rd(A_LO, 32'h0, `RESP_OKAY);
    rd(A_NONE, 32'h0, `RESP_SLVERR);
    wr(A_NONE, 8'hFF, `RESP_SLVERR);
    chk({29'h0, output_source}, {29'h0, `SRC_SINGLE});
  endtask

  task t_commit;
    wr(A_MODE, 8'h55, `RESP_OKAY);
    @(posedge mclk);
    chk({31'h0, lcd_enable}, 32'h1);
    chk({29'h0, output_source}, {29'h0, `SRC_SINGLE});
    wr(A_HI, 8'hA5, `RESP_OKAY);
    wr(A_MID, 8'h3C, `RESP_OKAY);
    wr(A_LO, 8'hFF, `RESP_OKAY);
    chk({8'h0, window_one_start_addr}, 32'h0);
    wr(A_COMMIT, 8'h80, `RESP_OKAY);
    @(posedge mclk);
    chk({29'h0, output_source}, {29'h0, `SRC_WINDOW_ONE});
    chk({28'h0, frame_buffer_index}, 32'h5);
    chk({8'h0, window_one_start_addr}, 32'hA53CF8);
  endtask

  // Every source code while the output keeps running
  task t_sources;
    integer c;
    for (c = 0; c < 8; c = c + 1)
    begin
      wr(A_MODE, {4'hF, c[2:0], 1'b1}, `RESP_OKAY);
      wr(A_COMMIT, 8'h80, `RESP_OKAY);
      @(posedge mclk);
      chk({29'h0, output_source}, c);
      chk({31'h0, double_buffer_active}, {31'h0, c == 1});
      chk({28'h0, frame_buffer_index}, (c == 1) ? 32'h0 : 32'hF);
      repeat (6) @(posedge mclk);
      if (c == 5) chk({8'h0, panel_data}, 32'h000000);
      if (c == 6) chk({8'h0, panel_data}, 32'hFFFFFF);
      if (c == 7)
      begin
        // Bars restart at a line strobe; first bar black, second blue
        line_strobe <= 1'b1;
        @(posedge mclk);
        line_strobe <= 1'b0;
        repeat (16) @(posedge mclk);
        chk({8'h0, panel_data}, 32'h000000);
        repeat (32) @(posedge mclk);
        chk({8'h0, panel_data}, 32'h0000FF);
      end
    end
  endtask

  // Launch edge seen by the panel for both settings
  task t_edge;
    integer e;
    logic [15:0] h0, m0;
    wr(A_MODE, 8'h01, `RESP_OKAY);
    wr(A_COMMIT, 8'h80, `RESP_OKAY);
    for (e = 0; e < 2; e = e + 1)
    begin
      wr(A_EDGE, {e[0], 7'h00}, `RESP_OKAY);
      edge_fall <= e[0];
      rd(A_EDGE, {24'h0, e[0], 7'h00}, `RESP_OKAY);
      repeat (4) @(posedge mclk);
      h0 = hit_cnt;
      m0 = miss_cnt;
      repeat (40) @(posedge mclk);
      chk({16'h0, miss_cnt - m0}, 32'h0);
      chk({16'h0, hit_cnt - h0}, 32'd20);
    end
  endtask

  // Vsync start counted in lines after non-display begins
  task t_vsync(input logic [7:0] n);
    integer c, lines, seen, hits;
    wr(A_VS, n, `RESP_OKAY);
    lines = 0;
    seen = -1;
    hits = 0;
    non_display_start <= 1'b1;
    for (c = 0; c < 40; c = c + 1)
    begin
      @(posedge mclk);
      if (vsync_start === 1'b1)
      begin
        seen = lines;
        hits = hits + 1;
      end
      non_display_start <= 1'b0;
      line_strobe <= (c % 4 == 2);
      if (c % 4 == 2) lines = lines + 1;
    end
    chk(seen, {24'h0, n});
    chk(hits, 32'h1);
  endtask

  task t_disable;
    // New source and buffer stay in the shadow, only enable acts
    wr(A_MODE, 8'hFE, `RESP_OKAY);
    @(posedge mclk);
    chk({31'h0, lcd_enable}, 32'h0);
    chk({29'h0, output_source}, {29'h0, `SRC_SINGLE});
    chk({28'h0, frame_buffer_index}, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, pclk_out}, 32'h0);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset_values();
    t_commit();
    t_sources();
    t_edge();
    t_vsync(8'h00);
    t_vsync(8'h03);
    t_disable();
    // Second reset mid-run must restore the vsync, edge, mode and low address registers
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset_values();
    stop_test();
  end
endmodule
`default_nettype wire
